// file: include/pfcd_pkg.sv
// package of command codes, identifier offsets and bus timing for the flash host
// assumes a 10 MHz system clock and a 16-bit flash data bus
package pfcd_pkg;
   // command codes written on the data lines
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'hE8;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_LOCK_SET = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN = 8'h2F;
   localparam logic [7:0] CMD_OTP_PROGRAM = 8'hC0;
   localparam logic [7:0] CMD_SET_READ_CFG = 8'h03;
   localparam logic [7:0] CMD_SET_PART_CFG = 8'h04;
   // identifier offsets on the low address lines
   localparam logic [15:0] ID_MAKER_OFS = 16'h0000;
   localparam logic [15:0] ID_DEVICE_OFS = 16'h0001;
   localparam logic [15:0] ID_READ_CFG_OFS = 16'h0005;
   localparam logic [15:0] ID_PART_CFG_OFS = 16'h0006;
   localparam logic [15:0] ID_OTP_LOCK_OFS = 16'h0080;
   localparam logic [15:0] ID_OTP_DATA_OFS = 16'h0081;
   // bus cycle timing, in ns and derived cycles
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_LOW_NS = 100;
   localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_NS = 200;
   localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host operations requested on the user port
   typedef enum logic [3:0] {
      PFCD_OP_READ_ARRAY = 4'h0,
      PFCD_OP_READ_ID = 4'h1,
      PFCD_OP_READ_QUERY = 4'h2,
      PFCD_OP_BLOCK_ERASE = 4'h3,
      PFCD_OP_CHIP_ERASE = 4'h4,
      PFCD_OP_PROGRAM = 4'h5,
      PFCD_OP_PAGE_PROGRAM = 4'h6,
      PFCD_OP_LOCK = 4'h7,
      PFCD_OP_OTP_PROGRAM = 4'h8,
      PFCD_OP_SET_CFG = 4'h9,
      PFCD_OP_SUSPEND = 4'hA,
      PFCD_OP_RESUME = 4'hB,
      PFCD_OP_READ_WORD = 4'hC
   } pfcd_op_e;
endpackage : pfcd_pkg

// file: core/pfcd_host.sv
// host that drives a partitioned flash command decoder through its parallel pins
// assumes the flash sits on pins with the chip select, write and output strobes active low
`timescale 1ns/1ps
module pfcd_host #(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16,
   parameter int MAX_WORDS = 32
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // user request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [3:0] req_op,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_data,
   input wire logic [7:0] req_sub,
   input wire logic engine_busy,
   // page buffer data feed
   input wire logic [DATA_W-1:0] page_data,
   input wire logic [5:0] page_count,
   output logic page_take,
   // read answer
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic refused,
   // flash pins
   output logic [ADDR_W-1:0] fl_addr,
   output logic [DATA_W-1:0] fl_dq_o,
   output logic fl_dq_oe,
   input wire logic [DATA_W-1:0] fl_dq_i,
   output logic fl_ce_n,
   output logic fl_we_n,
   output logic fl_oe_n,
   output logic fl_rst_n
);
   // host sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_WR_LOW = 3'b001, ST_WR_HIGH = 3'b010, ST_RD_LOW = 3'b011, ST_DONE = 3'b100
   } pfcd_state_e;
   pfcd_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d; // strobe timing counter
   logic [2:0] step_q, step_d; // write index in the sequence
   logic [5:0] words_q, words_d; // page words still to load
   logic [3:0] op_q, op_d; // held operation
   logic [ADDR_W-1:0] base_q, base_d; // address of first cycle
   logic [DATA_W-1:0] dat_q, dat_d; // held data word
   logic [7:0] sub_q, sub_d; // second lock/config code
   logic [ADDR_W-1:0] fa_q, fa_d; // address on the pins
   logic [DATA_W-1:0] fd_q, fd_d; // data on the pins
   logic [DATA_W-1:0] rd_q, rd_d; // captured read word
   logic rdv_q, rdv_d, ref_q, ref_d, take_q, take_d;
   logic [DATA_W-1:0] dq_s1_q, dq_s2_q; // data pin synchroniser
   logic last_w;

   // pad a command byte onto the data lines
   function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] c);
      cmd_word = {{(DATA_W-8){1'b0}}, c};
   endfunction : cmd_word

   // number of command writes for each operation, zero means a pure read
   function automatic logic [2:0] write_count(input logic [3:0] op);
      case (op)
         pfcd_pkg::PFCD_OP_READ_WORD: write_count = 3'd0;
         pfcd_pkg::PFCD_OP_READ_ARRAY, pfcd_pkg::PFCD_OP_READ_ID, pfcd_pkg::PFCD_OP_READ_QUERY,
         pfcd_pkg::PFCD_OP_SUSPEND, pfcd_pkg::PFCD_OP_RESUME: write_count = 3'd1;
         pfcd_pkg::PFCD_OP_PAGE_PROGRAM: write_count = 3'd4;
         default: write_count = 3'd2;
      endcase
   endfunction : write_count

   // ops that start the write engine
   function automatic logic is_alter(input logic [3:0] op);
      is_alter = (op == pfcd_pkg::PFCD_OP_BLOCK_ERASE) || (op == pfcd_pkg::PFCD_OP_CHIP_ERASE) ||
                 (op == pfcd_pkg::PFCD_OP_PROGRAM) || (op == pfcd_pkg::PFCD_OP_PAGE_PROGRAM) ||
                 (op == pfcd_pkg::PFCD_OP_OTP_PROGRAM);
   endfunction : is_alter

   assign req_ready = (st_q == ST_IDLE);
   assign last_w = (step_q + 3'd1 >= write_count(op_q)) && (words_q == 6'd0);

   // sequencer next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      step_d = step_q;
      words_d = words_q;
      op_d = op_q;
      base_d = base_q;
      dat_d = dat_q;
      sub_d = sub_q;
      fa_d = fa_q;
      fd_d = fd_q;
      rd_d = rd_q;
      rdv_d = 1'b0;
      ref_d = 1'b0;
      take_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               if (is_alter(req_op) && engine_busy) begin
                  ref_d = 1'b1; // engine must be idle everywhere
               end else begin
                  op_d = req_op;
                  base_d = req_addr; // command writes carry the address, set config replaces its low 16 lines
                  dat_d = req_data;
                  sub_d = req_sub;
                  step_d = 3'd0;
                  words_d = 6'd0;
                  cnt_d = 4'd0;
                  fa_d = req_addr;
                  st_d = (write_count(req_op) == 3'd0) ? ST_RD_LOW : ST_WR_LOW; // single read
                  case (req_op)
                     pfcd_pkg::PFCD_OP_READ_ARRAY: fd_d = cmd_word(pfcd_pkg::CMD_READ_ARRAY);
                     pfcd_pkg::PFCD_OP_READ_ID: fd_d = cmd_word(pfcd_pkg::CMD_READ_ID);
                     pfcd_pkg::PFCD_OP_READ_QUERY: fd_d = cmd_word(pfcd_pkg::CMD_READ_QUERY);
                     pfcd_pkg::PFCD_OP_BLOCK_ERASE: fd_d = cmd_word(pfcd_pkg::CMD_BLOCK_ERASE);
                     pfcd_pkg::PFCD_OP_CHIP_ERASE: fd_d = cmd_word(pfcd_pkg::CMD_CHIP_ERASE);
                     pfcd_pkg::PFCD_OP_PROGRAM: fd_d = cmd_word(pfcd_pkg::CMD_PROGRAM);
                     pfcd_pkg::PFCD_OP_PAGE_PROGRAM: fd_d = cmd_word(pfcd_pkg::CMD_PAGE_PROGRAM);
                     pfcd_pkg::PFCD_OP_OTP_PROGRAM: fd_d = cmd_word(pfcd_pkg::CMD_OTP_PROGRAM);
                     pfcd_pkg::PFCD_OP_SUSPEND: fd_d = cmd_word(pfcd_pkg::CMD_SUSPEND);
                     pfcd_pkg::PFCD_OP_RESUME: fd_d = cmd_word(pfcd_pkg::CMD_CONFIRM);
                     default: fd_d = cmd_word(pfcd_pkg::CMD_LOCK_SETUP); // lock and config setup
                  endcase
                  if (req_op == pfcd_pkg::PFCD_OP_SET_CFG) begin
                     fa_d = {req_addr[ADDR_W-1:16], req_data}; // value on low 16 lines
                     base_d = {req_addr[ADDR_W-1:16], req_data};
                  end
               end
            end
         end
         ST_WR_LOW: begin
            // both strobes low; data held stable through the rise
            if (cnt_q + 4'd1 >= 4'(pfcd_pkg::STROBE_CYC)) begin
               cnt_d = 4'd0;
               st_d = ST_WR_HIGH;
            end else begin
               cnt_d = cnt_q + 4'd1;
            end
         end
         ST_WR_HIGH: begin
            // strobes high; prepare the next write of the sequence
            if (last_w) begin
               st_d = ST_DONE;
            end else begin
               st_d = ST_WR_LOW;
               fa_d = base_q; // same address on second cycle
               if (op_q == pfcd_pkg::PFCD_OP_PAGE_PROGRAM) begin
                  // count, then address/data pairs, then confirm
                  if (step_q == 3'd0) begin
                     fd_d = {{(DATA_W-6){1'b0}}, page_count};
                     words_d = page_count + 6'd1;
                     step_d = 3'd1;
                  end else if (words_q != 6'd0) begin
                     fa_d = ADDR_W'(base_q + ADDR_W'(page_count + 6'd1 - words_q));
                     fd_d = page_data;
                     take_d = 1'b1;
                     words_d = words_q - 6'd1;
                     step_d = (words_q == 6'd1) ? 3'd2 : 3'd1;
                  end else begin
                     fd_d = cmd_word(pfcd_pkg::CMD_CONFIRM);
                     step_d = 3'd3;
                  end
               end else begin
                  step_d = step_q + 3'd1;
                  case (op_q)
                     pfcd_pkg::PFCD_OP_BLOCK_ERASE, pfcd_pkg::PFCD_OP_CHIP_ERASE:
                        fd_d = cmd_word(pfcd_pkg::CMD_CONFIRM);
                     pfcd_pkg::PFCD_OP_LOCK: fd_d = cmd_word(sub_q); // 01, D0 or 2F
                     pfcd_pkg::PFCD_OP_SET_CFG: fd_d = cmd_word(sub_q); // 03 or 04
                     default: fd_d = dat_q; // program and otp data word
                  endcase
               end
            end
         end
         ST_RD_LOW: begin
            // chip select and output enable low for one single read
            if (cnt_q + 4'd1 >= 4'(pfcd_pkg::READ_CYC) + 4'd2) begin
               rd_d = dq_s2_q;
               rdv_d = 1'b1;
               cnt_d = 4'd0;
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + 4'd1;
            end
         end
         ST_DONE: begin
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // registers, frozen while the enable is low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         step_q <= 3'h0;
         words_q <= 6'h0;
         op_q <= 4'h0;
         base_q <= '0;
         dat_q <= '0;
         sub_q <= 8'h00;
         fa_q <= '0;
         fd_q <= '0;
         rd_q <= '0;
         rdv_q <= 1'b0;
         ref_q <= 1'b0;
         take_q <= 1'b0;
         dq_s1_q <= '0;
         dq_s2_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         step_q <= step_d;
         words_q <= words_d;
         op_q <= op_d;
         base_q <= base_d;
         dat_q <= dat_d;
         sub_q <= sub_d;
         fa_q <= fa_d;
         fd_q <= fd_d;
         rd_q <= rd_d;
         rdv_q <= rdv_d;
         ref_q <= ref_d;
         take_q <= take_d;
         dq_s1_q <= fl_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // pins: reset pin low during system reset puts every partition in array read
   assign fl_rst_n = ~sys_rst;
   assign fl_addr = fa_q;
   assign fl_dq_o = fd_q;
   assign fl_dq_oe = (st_q == ST_WR_LOW) || (st_q == ST_WR_HIGH);
   assign fl_ce_n = ~((st_q == ST_WR_LOW) || (st_q == ST_RD_LOW));
   assign fl_we_n = ~(st_q == ST_WR_LOW);
   assign fl_oe_n = ~(st_q == ST_RD_LOW); // never with write strobe low
   assign rd_valid = rdv_q;
   assign rd_data = rd_q;
   assign refused = ref_q;
   assign page_take = take_q;

   // checks
   property p_no_oe_we;
      @(posedge clk) disable iff (sys_rst) !(!fl_oe_n && !fl_we_n);
   endproperty
   a_no_oe_we: assert property (p_no_oe_we) else $error("oe and we low together");
   property p_refuse_busy;
      @(posedge clk) disable iff (sys_rst)
         (clk_en && req_valid && req_ready && engine_busy && is_alter(req_op)) |=> refused && req_ready;
   endproperty
   a_refuse_busy: assert property (p_refuse_busy) else $error("alter op issued while busy");
   property p_strobe_rise;
      @(posedge clk) disable iff (sys_rst) $rose(fl_we_n) |-> (fl_addr == $past(fl_addr) && fl_dq_o == $past(fl_dq_o));
   endproperty
   a_strobe_rise: assert property (p_strobe_rise) else $error("bus changed at strobe rise");
   // the address moves with the fall of the output strobe, so only later cycles must hold it
   property p_read_single;
      @(posedge clk) disable iff (sys_rst) (!fl_oe_n && !$past(fl_oe_n)) |-> $stable(fl_addr);
   endproperty
   a_read_single: assert property (p_read_single) else $error("address moved in read");
   // a taken single read: strobes low for the access, then the word is handed over
   sequence s_rd_take;
      req_valid && req_ready && (req_op == pfcd_pkg::PFCD_OP_READ_WORD);
   endsequence
   sequence s_rd_hold;
      (!fl_oe_n && !fl_ce_n) [*4] ##1 rd_valid;
   endsequence
   // a frozen enable stretches the access, so those attempts are dropped
   property p_read_answer;
      @(posedge clk) disable iff (sys_rst || !clk_en) s_rd_take |=> s_rd_hold;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("single read answer out of time");
   // a taken block erase: setup code, strobe high, then confirm at the same address
   sequence s_erase_take;
      req_valid && req_ready && !engine_busy && (req_op == pfcd_pkg::PFCD_OP_BLOCK_ERASE);
   endsequence
   sequence s_erase_writes;
      (!fl_we_n && fl_dq_o[7:0] == pfcd_pkg::CMD_BLOCK_ERASE) ##1 fl_we_n
         ##1 (!fl_we_n && fl_dq_o[7:0] == pfcd_pkg::CMD_CONFIRM && fl_addr == $past(fl_addr, 2));
   endsequence
   property p_erase_pair;
      @(posedge clk) disable iff (sys_rst || !clk_en) s_erase_take |=> s_erase_writes;
   endproperty
   a_erase_pair: assert property (p_erase_pair) else $error("block erase pair malformed");
endmodule : pfcd_host

// file: sim/pfcd_flash_model.sv
// behavioural flash partner: per-partition read modes and a log of every latched write
// assumes four partitions selected by the top two address lines
`timescale 1ns/1ps
module pfcd_flash_model #(
   parameter logic [15:0] MAKER_CODE = 16'h00C3, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0042 // arbitrary value
) (
   // flash pins
   input wire logic [20:0] fl_addr,
   input wire logic [15:0] fl_dq_o,
   input wire logic fl_dq_oe,
   output logic [15:0] fl_dq_i,
   input wire logic fl_ce_n,
   input wire logic fl_we_n,
   input wire logic fl_oe_n,
   input wire logic fl_rst_n,
   // write engine state seen by the partner
   input wire logic engine_busy
);
   logic [1:0] mode [4] = '{default: 2'd0}; // 0 array, 1 identifier, 2 query
   logic [1:0] run_p = 2'd0; // partition of the last block erase, program or page program
   logic ign = 1'b0; // read command aimed at the partition still running
   logic [20:0] log_a [64]; // latched write addresses
   logic [15:0] log_d [64]; // latched write data
   int wr_n = 0; // writes latched so far
   int skip = 0; // writes still owed to a setup code, -1 waits for a count
   logic act = 1'b0; // both strobes low
   logic [15:0] rd_v; // word the array would present
   logic [15:0] last = 16'h0000; // last word driven, inverted once released
   // latch on whichever strobe rises first
   always @(fl_ce_n or fl_we_n or fl_rst_n) begin
      if (!fl_rst_n) begin
         mode = '{default: 2'd0}; // every partition back to array read
         skip = 0;
      end else if (act && (fl_ce_n || fl_we_n)) begin
         log_a[wr_n[5:0]] = fl_addr;
         log_d[wr_n[5:0]] = fl_dq_o;
         wr_n++;
         if (skip < 0) skip = int'(fl_dq_o[5:0]) + 2; // n+1 words then confirm
         else if (skip > 0) skip--; // second cycles are data
         else begin
            // only the addressed partition changes mode
            // a running partition ignores array and identifier read commands, the others take them
            ign = engine_busy && (fl_addr[20:19] == run_p);
            case (fl_dq_o[7:0])
               8'hFF: if (!ign) mode[fl_addr[20:19]] = 2'd0;
               8'h90: if (!ign) mode[fl_addr[20:19]] = 2'd1;
               8'h98: mode[fl_addr[20:19]] = 2'd2;
               8'h20, 8'h40, 8'h10: begin
                  skip = 1;
                  run_p = fl_addr[20:19];
               end
               8'h30, 8'h60, 8'hC0: skip = 1;
               8'hE8: begin
                  skip = -1;
                  run_p = fl_addr[20:19];
               end
               default: ; // undefined codes, suspend and resume keep the mode
            endcase
         end
      end
      act = fl_rst_n && !fl_ce_n && !fl_we_n;
   end
   // read value by partition mode
   always_comb begin
      case (mode[fl_addr[20:19]])
         2'd1: rd_v = (fl_addr[15:0] == 16'h0000) ? MAKER_CODE :
                      (fl_addr[15:0] == 16'h0001) ? DEVICE_CODE : 16'h0000;
         2'd2: rd_v = {8'h10, fl_addr[7:0]};
         default: rd_v = fl_addr[15:0] ^ 16'h5A5A;
      endcase
   end
   // released bus is not kept: shows the inverse of the last word
   always @* begin
      if (fl_dq_oe) fl_dq_i = fl_dq_o;
      else if (!fl_ce_n && !fl_oe_n && fl_rst_n) begin
         fl_dq_i = rd_v; // one word per access
         last = rd_v;
      end else fl_dq_i = ~last;
   end
endmodule : pfcd_flash_model

// file: sim/tb_top.sv
// self-checking bench: host requests in, pin writes judged through the partner log
// assumes the partner model above and a 10 MHz clock
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, engine_busy = 1'b0, clk_en = 1'b1;
   logic [3:0] req_op = 4'h0;
   logic [20:0] req_addr = 21'h000000, fa;
   logic [15:0] req_data = 16'h0000, rd_data, rd_got, dq_o, dq_i;
   logic [7:0] req_sub = 8'h00;
   logic [5:0] page_count = 6'h00;
   logic [15:0] page_idx = 16'h0000; // page words consumed
   logic req_ready, page_take, rd_valid, refused, dq_oe, ce_n, we_n, oe_n, rst_n, got_rd, got_ref;
   int n_mismatch = 0, check_count = 0, rp = 0, cyc = 0;
   pfcd_host #(.ADDR_W(21), .DATA_W(16), .MAX_WORDS(32)) dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .req_sub(req_sub), .engine_busy(engine_busy), .page_data(16'hC000 + page_idx), .page_count(page_count),
      .page_take(page_take), .rd_valid(rd_valid), .rd_data(rd_data), .refused(refused), .fl_addr(fa),
      .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
      .fl_rst_n(rst_n));
   pfcd_flash_model flash_u (.fl_addr(fa), .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i), .fl_ce_n(ce_n),
      .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_rst_n(rst_n), .engine_busy(engine_busy));
   // free-running clock
   initial forever #50 clk = ~clk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // next page word presented once the host takes one
   always @(negedge clk) if (page_take === 1'b1) page_idx <= page_idx + 16'h0001;
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // next logged pin write against the expected pair
   task automatic exp_wr(input logic [20:0] a, input logic [15:0] d);
      chk({11'h0, a}, {11'h0, flash_u.log_a[rp[5:0]]});
      chk({16'h0, d}, {16'h0, flash_u.log_d[rp[5:0]]});
      rp++;
   endtask : exp_wr
   // one request, held for one cycle, then wait for ready with pulses noted
   task automatic req(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d, input logic [7:0] s);
      int k;
      got_rd = 1'b0;
      got_ref = 1'b0;
      @(negedge clk);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_data = d;
      req_sub = s;
      @(negedge clk);
      req_valid = 1'b0;
      for (k = 0; k < 60; k++) begin
         if (rd_valid === 1'b1) begin
            got_rd = 1'b1;
            rd_got = rd_data;
         end
         if (refused === 1'b1) got_ref = 1'b1;
         if (req_ready === 1'b1 && k > 0) break;
         @(negedge clk);
      end
      chk(32'h1, {31'h0, req_ready});
   endtask : req
   // request with two logged writes at one address, none extra
   task automatic op2(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d, input logic [7:0] s,
                      input logic [20:0] wa, input logic [15:0] c1, input logic [15:0] c2);
      req(op, a, d, s);
      exp_wr(wa, c1);
      exp_wr(wa, c2);
      chk(rp, flash_u.wr_n);
   endtask : op2
   // read one word and compare
   task automatic rd(input logic [20:0] a, input logic [15:0] e);
      req(pfcd_pkg::PFCD_OP_READ_WORD, a, 16'h0000, 8'h00);
      chk({15'h0, got_rd, e}, {15'h0, 1'b1, rd_got});
   endtask : rd
   // two-cycle writes for erase, program, lock, config and one-time block
   task automatic t_two_cycle();
      logic [7:0] subs [3] = '{8'h01, 8'hD0, 8'h2F};
      op2(pfcd_pkg::PFCD_OP_BLOCK_ERASE, 21'h0A1234, 16'h0, 8'h0, 21'h0A1234, 16'h0020, 16'h00D0);
      op2(pfcd_pkg::PFCD_OP_CHIP_ERASE, 21'h1F0000, 16'h0, 8'h0, 21'h1F0000, 16'h0030, 16'h00D0);
      op2(pfcd_pkg::PFCD_OP_PROGRAM, 21'h0B0002, 16'hBEEF, 8'h0, 21'h0B0002, 16'h0040, 16'hBEEF);
      foreach (subs[i]) op2(pfcd_pkg::PFCD_OP_LOCK, 21'h120400, 16'h0, subs[i], 21'h120400, 16'h0060,
                            {8'h00, subs[i]});
      op2(pfcd_pkg::PFCD_OP_SET_CFG, 21'h100000, 16'h1234, 8'h03, 21'h101234, 16'h0060, 16'h0003);
      op2(pfcd_pkg::PFCD_OP_SET_CFG, 21'h100000, 16'h4321, 8'h04, 21'h104321, 16'h0060, 16'h0004);
      op2(pfcd_pkg::PFCD_OP_OTP_PROGRAM, 21'h000081, 16'hA55A, 8'h0, 21'h000081, 16'h00C0, 16'hA55A);
   endtask : t_two_cycle
   // page program of three words, confirm at the start address
   task automatic t_page();
      page_idx = 16'h0000;
      page_count = 6'h02;
      req(pfcd_pkg::PFCD_OP_PAGE_PROGRAM, 21'h0C0010, 16'h0, 8'h0);
      exp_wr(21'h0C0010, 16'h00E8);
      exp_wr(21'h0C0010, 16'h0002);
      for (int i = 0; i < 3; i++) exp_wr(21'h0C0010 + 21'(i), 16'hC000 + 16'(i));
      exp_wr(21'h0C0010, 16'h00D0);
      chk(rp, flash_u.wr_n);
   endtask : t_page
   // busy engine: erase refused with pins quiet, suspend and resume still written
   task automatic t_busy();
      engine_busy = 1'b1;
      req(pfcd_pkg::PFCD_OP_BLOCK_ERASE, 21'h0A0000, 16'h0, 8'h0);
      chk(32'h1, {31'h0, got_ref});
      chk(rp, flash_u.wr_n);
      req(pfcd_pkg::PFCD_OP_SUSPEND, 21'h0A0000, 16'h0, 8'h0);
      exp_wr(21'h0A0000, 16'h00B0);
      req(pfcd_pkg::PFCD_OP_RESUME, 21'h0A0000, 16'h0, 8'h0);
      exp_wr(21'h0A0000, 16'h00D0);
      // identifier code to the running partition is ignored, to another one taken
      req(pfcd_pkg::PFCD_OP_READ_ID, 21'h0A0000, 16'h0, 8'h0);
      exp_wr(21'h0A0000, 16'h0090);
      rd(21'h0A0000, 16'h5A5A);
      req(pfcd_pkg::PFCD_OP_READ_ID, 21'h180000, 16'h0, 8'h0);
      exp_wr(21'h180000, 16'h0090);
      rd(21'h180000, flash_u.MAKER_CODE);
      req(pfcd_pkg::PFCD_OP_READ_ARRAY, 21'h180000, 16'h0, 8'h0);
      exp_wr(21'h180000, 16'h00FF);
      engine_busy = 1'b0;
   endtask : t_busy
   // enable low: a request is not taken and the pins stay quiet
   task automatic t_freeze();
      clk_en = 1'b0;
      req(pfcd_pkg::PFCD_OP_READ_ARRAY, 21'h000000, 16'h0, 8'h0);
      chk(rp, flash_u.wr_n);
      chk(32'h3, {30'h0, ce_n, we_n});
      clk_en = 1'b1;
   endtask : t_freeze
   // mid-run reset: the identifier partition falls back to array read
   task automatic t_reset();
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      chk(32'h0, {31'h0, rst_n});
      sys_rst = 1'b0;
      rd(21'h080005, 16'h5A5F);
   endtask : t_reset
   // read modes per partition: identifier, query, back to array
   task automatic t_modes();
      req(pfcd_pkg::PFCD_OP_READ_ID, 21'h080000, 16'h0, 8'h0);
      exp_wr(21'h080000, 16'h0090);
      rd(21'h080000, flash_u.MAKER_CODE);
      rd(21'h080001, flash_u.DEVICE_CODE);
      rd(21'h000005, 16'h5A5F);
      req(pfcd_pkg::PFCD_OP_READ_QUERY, 21'h180010, 16'h0, 8'h0);
      exp_wr(21'h180010, 16'h0098);
      rd(21'h180010, 16'h1010);
      req(pfcd_pkg::PFCD_OP_READ_ARRAY, 21'h180010, 16'h0, 8'h0);
      exp_wr(21'h180010, 16'h00FF);
      rd(21'h180010, 16'h5A4A);
   endtask : t_modes
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // main sequence: reset held five cycles, pins checked while held
   initial begin
      repeat (3) @(negedge clk);
      chk(32'h3, {30'h0, ce_n, we_n});
      chk(32'h0, {31'h0, rst_n});
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      rd(21'h100123, 16'h5B79);
      t_freeze();
      t_two_cycle();
      t_page();
      t_busy();
      t_modes();
      t_reset();
      conclude();
   end
endmodule : tb_top
